//--- include/ilsu_op_if.sv
// Decoded load/store operation passed from the decoder to the unit core
`timescale 1ns/1ns
interface ilsu_op_if import ilsu_pkg::*; ();
    logic legal;
    logic is_load;
    ilsu_size_t size;
    logic sign;
    logic indexed;
    logic update;
    logic [4:0] rt;
    logic [4:0] ra;
    logic [4:0] rb;
    logic [15:0] simm;

    modport dec (output legal, is_load, size, sign, indexed, update, rt, ra, rb, simm);
    modport core (input legal, is_load, size, sign, indexed, update, rt, ra, rb, simm);
endinterface

//--- include/ilsu_pkg.sv
// Shared constants, types and decode helper of the integer load/store unit
package ilsu_pkg;

    // Instruction field positions (bit 0 is the least significant bit)
    localparam int unsigned OPC_LSB = 26;
    localparam int unsigned RT_LSB = 21;
    localparam int unsigned RA_LSB = 16;
    localparam int unsigned RB_LSB = 11;
    localparam int unsigned D_KIND_LSB = 27;
    localparam int unsigned D_UPD_BIT = 26;
    localparam int unsigned XO_LSB = 1;
    localparam int unsigned X_UPD_BIT = 6;
    localparam int unsigned X_KIND_LSB = 7;
    localparam int unsigned X_KIND_HI_BIT = 10;

    // Opcode patterns of the load/store group
    localparam logic [5:0] OP_EXT = 6'h1F;
    localparam logic [1:0] OP_DFORM_HI = 2'h2;
    localparam logic [4:0] XO_LS_LOW = 5'h17;

    // Kind codes shared by the immediate and indexed encodings
    localparam logic [2:0] KIND_LWZ = 3'h0;
    localparam logic [2:0] KIND_LBZ = 3'h1;
    localparam logic [2:0] KIND_STW = 3'h2;
    localparam logic [2:0] KIND_STB = 3'h3;
    localparam logic [2:0] KIND_LHZ = 3'h4;
    localparam logic [2:0] KIND_LHA = 3'h5;
    localparam logic [2:0] KIND_STH = 3'h6;
    localparam logic [2:0] KIND_NONE = 3'h7;

    localparam logic [4:0] REG_ZERO = 5'h00;

    typedef enum logic [1:0] {ILSU_SZ_BYTE, ILSU_SZ_HALF, ILSU_SZ_WORD} ilsu_size_t;

    typedef struct packed {
        logic is_load;
        ilsu_size_t size;
        logic sign;
    } ilsu_attr_t;

    typedef enum logic [1:0] {ILSU_IDLE, ILSU_ACCESS, ILSU_UPDATE} ilsu_fsm_t;

    typedef struct packed {
        ilsu_fsm_t st;
        logic busy;
        logic done;
        logic bad_form;
        logic is_load;
        ilsu_size_t size;
        logic sign;
        logic update;
        logic [4:0] rt;
        logic [4:0] ra;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [3:0] mem_be;
        logic [31:0] mem_wdata;
        logic rf_we;
        logic wb_load;
        logic [4:0] rf_waddr;
        logic [31:0] rf_wdata;
    } ilsu_regs_t;

    localparam ilsu_regs_t ILSU_REGS_RST = '0;

    // Access size, extension and direction of one kind code
    function automatic ilsu_attr_t ilsu_kind_attr(input logic [2:0] kind);
        ilsu_attr_t a;
        a = '{is_load: 1'b1, size: ILSU_SZ_WORD, sign: 1'b0};
        case (kind)
            KIND_LBZ: a.size = ILSU_SZ_BYTE;
            KIND_LHZ: a.size = ILSU_SZ_HALF;
            KIND_LHA: a = '{is_load: 1'b1, size: ILSU_SZ_HALF, sign: 1'b1};
            KIND_STW: a.is_load = 1'b0;
            KIND_STB: a = '{is_load: 1'b0, size: ILSU_SZ_BYTE, sign: 1'b0};
            KIND_STH: a = '{is_load: 1'b0, size: ILSU_SZ_HALF, sign: 1'b0};
            default: a.size = ILSU_SZ_WORD;
        endcase
        return a;
    endfunction

endpackage

//--- rtl/ilsu_decode.sv
// Opcode decoder of the integer load/store unit
`timescale 1ns/1ns
module ilsu_decode import ilsu_pkg::*; (
    input wire logic [31:0] instr_i,
    ilsu_op_if.dec op
);
    logic [5:0] opc;
    logic [2:0] dk;
    logic [2:0] xk;
    logic d_ok;
    logic x_ok;
    ilsu_attr_t da;
    ilsu_attr_t xa;

    always_comb begin
        opc = instr_i[OPC_LSB +: 6];
        dk = instr_i[D_KIND_LSB +: 3];
        xk = instr_i[X_KIND_LSB +: 3];
        d_ok = (opc[5:4] == OP_DFORM_HI) && (dk != KIND_NONE);
        x_ok = (opc == OP_EXT) && (instr_i[XO_LSB +: 5] == XO_LS_LOW)
            && !instr_i[X_KIND_HI_BIT] && (xk != KIND_NONE);
        da = ilsu_kind_attr(dk);
        xa = ilsu_kind_attr(xk);
        op.legal = d_ok || x_ok;
        op.indexed = x_ok;
        op.is_load = x_ok ? xa.is_load : da.is_load;
        op.size = x_ok ? xa.size : da.size;
        op.sign = x_ok ? xa.sign : da.sign;
        op.update = x_ok ? instr_i[X_UPD_BIT] : instr_i[D_UPD_BIT];
        op.rt = instr_i[RT_LSB +: 5];
        op.ra = instr_i[RA_LSB +: 5];
        op.rb = instr_i[RB_LSB +: 5];
        op.simm = instr_i[15:0];
    end
endmodule

//--- rtl/ilsu_lane.sv
// Big-endian byte lane steering for load extension and store data
`timescale 1ns/1ns
module ilsu_lane import ilsu_pkg::*; (
    input wire ilsu_size_t ld_size_i,
    input wire logic ld_sign_i,
    input wire logic [1:0] ld_lo_i,
    input wire logic [31:0] rdata_i,
    input wire ilsu_size_t st_size_i,
    input wire logic [1:0] st_lo_i,
    input wire logic [31:0] sdata_i,
    output logic [31:0] ld_val_o,
    output logic [31:0] st_data_o,
    output logic [3:0] st_be_o
);
    logic [7:0] ld_byte;
    logic [15:0] ld_half;

    // Byte at offset k of a word sits in bits 31-8k downward
    for (genvar k = 0; k < 4; k++) begin : g_lane
        assign st_be_o[3 - k] = (st_size_i == ILSU_SZ_WORD)
            || ((st_size_i == ILSU_SZ_HALF) && (st_lo_i[1] == 1'(k / 2)))
            || ((st_size_i == ILSU_SZ_BYTE) && (st_lo_i == 2'(k)));
    end

    always_comb begin
        ld_byte = rdata_i[8 * (3 - ld_lo_i) +: 8];
        ld_half = ld_lo_i[1] ? rdata_i[15:0] : rdata_i[31:16];
        case (ld_size_i)
            ILSU_SZ_BYTE: ld_val_o = {24'h000000, ld_byte};
            ILSU_SZ_HALF: ld_val_o = {{16{ld_sign_i & ld_half[15]}}, ld_half};
            default: ld_val_o = rdata_i;
        endcase
        case (st_size_i)
            ILSU_SZ_BYTE: st_data_o = {4{sdata_i[7:0]}};
            ILSU_SZ_HALF: st_data_o = {2{sdata_i[15:0]}};
            default: st_data_o = sdata_i;
        endcase
    end
endmodule

//--- rtl/ilsu_top.sv
// Integer load/store unit: address forming, memory access, write-back
// What this block does
// - Zero-extending narrow loads clear unused high bits
// - Sign-extending loads copy operand top bit upward
// - Byte load: low eight bits, upper 24 zero
// - Halfword zero load: low 16, upper 16 zero
// - Halfword algebraic load replicates bit 15 upward
// - Word load passes all 32 bits unchanged
// - Immediate update: base plus displacement, written back
// - Indexed update: base plus index, written back
// - Load update with base zero or destination: flagged
// - Store update with base zero: flagged, undefined
// - Store update writes memory before base write-back
// - Byte store writes source low eight bits
// - Halfword store writes source low 16 bits
// - Word store writes all 32 source bits
// - Displacement sign-extended to 32 bits before add
// - Non-update base field zero contributes zero
`timescale 1ns/1ns
module ilsu_top import ilsu_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic issue_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] base_val_i,
    input wire logic [31:0] index_val_i,
    input wire logic [31:0] source_val_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output logic busy_o,
    output logic done_o,
    output logic bad_form_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [3:0] mem_be_o,
    output logic [31:0] mem_wdata_o,
    output logic rf_we_o,
    output logic [4:0] rf_waddr_o,
    output logic [31:0] rf_wdata_o
);
    ilsu_regs_t q;
    ilsu_regs_t d;

    ilsu_op_if op_if ();

    logic accept;
    logic [31:0] base_term;
    logic [31:0] offset;
    logic [31:0] ea;
    logic bad_now;
    logic [31:0] ld_val;
    logic [31:0] st_data;
    logic [3:0] st_be;

    ilsu_decode u_decode (
        .instr_i(instr_i),
        .op(op_if.dec)
    );

    ilsu_lane u_lane (
        .ld_size_i(q.size),
        .ld_sign_i(q.sign),
        .ld_lo_i(q.mem_addr[1:0]),
        .rdata_i(mem_rdata_i),
        .st_size_i(op_if.size),
        .st_lo_i(ea[1:0]),
        .sdata_i(source_val_i),
        .ld_val_o(ld_val),
        .st_data_o(st_data),
        .st_be_o(st_be)
    );

    // Effective address forming
    always_comb begin
        accept = (q.st == ILSU_IDLE) && issue_valid_i && op_if.legal;
        base_term = ((op_if.ra == REG_ZERO) && !op_if.update) ? 32'h00000000 : base_val_i;
        offset = op_if.indexed ? index_val_i : {{16{op_if.simm[15]}}, op_if.simm};
        ea = base_term + offset;
        // Invalid update forms run anyway; the result is left undefined
        bad_now = op_if.update && ((op_if.ra == REG_ZERO)
            || (op_if.is_load && (op_if.ra == op_if.rt)));
    end

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rf_we = 1'b0;
        d.wb_load = 1'b0;
        case (q.st)
            ILSU_IDLE: begin
                if (accept) begin
                    d.st = ILSU_ACCESS;
                    d.busy = 1'b1;
                    d.bad_form = bad_now;
                    d.is_load = op_if.is_load;
                    d.size = op_if.size;
                    d.sign = op_if.sign;
                    d.update = op_if.update;
                    d.rt = op_if.rt;
                    d.ra = op_if.ra;
                    d.mem_req = 1'b1;
                    d.mem_we = !op_if.is_load;
                    d.mem_addr = ea;
                    d.mem_be = st_be;
                    // Source is captured here, before any base write-back
                    d.mem_wdata = op_if.is_load ? 32'h00000000 : st_data;
                end
            end
            ILSU_ACCESS: begin
                if (mem_ack_i) begin
                    d.mem_req = 1'b0;
                    d.mem_we = 1'b0;
                    if (q.is_load) begin
                        d.rf_we = 1'b1;
                        d.wb_load = 1'b1;
                        d.rf_waddr = q.rt;
                        d.rf_wdata = ld_val;
                        d.st = q.update ? ILSU_UPDATE : ILSU_IDLE;
                    end else begin
                        d.rf_we = q.update;
                        d.rf_waddr = q.ra;
                        d.rf_wdata = q.mem_addr;
                        d.st = ILSU_IDLE;
                    end
                    d.busy = q.is_load && q.update;
                    d.done = !(q.is_load && q.update);
                end
            end
            ILSU_UPDATE: begin
                // Base write-back comes last, so a base equal to the target keeps the address
                d.rf_we = 1'b1;
                d.rf_waddr = q.ra;
                d.rf_wdata = q.mem_addr;
                d.st = ILSU_IDLE;
                d.busy = 1'b0;
                d.done = 1'b1;
            end
            default: d = ILSU_REGS_RST;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q <= ILSU_REGS_RST;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;
    assign bad_form_o = q.bad_form;
    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.mem_we;
    assign mem_addr_o = q.mem_addr;
    assign mem_be_o = q.mem_be;
    assign mem_wdata_o = q.mem_wdata;
    assign rf_we_o = q.rf_we;
    assign rf_waddr_o = q.rf_waddr;
    assign rf_wdata_o = q.rf_wdata;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i || !clk_en_i);

    zero_ext_byte_a: assert property (
        (q.st == ILSU_ACCESS && mem_ack_i && q.is_load && q.size == ILSU_SZ_BYTE)
        |=> rf_we_o && rf_wdata_o == {24'h000000, $past(ld_val[7:0])}
            && rf_wdata_o[7:0] == $past(mem_rdata_i[8 * (3 - q.mem_addr[1:0]) +: 8]))
        else $error("byte load not zero extended");

    zero_ext_half_a: assert property (
        (rf_we_o && q.wb_load && q.size == ILSU_SZ_HALF && !q.sign)
        |-> rf_wdata_o[31:16] == 16'h0000)
        else $error("halfword zero load has upper bits set");

    sign_ext_half_a: assert property (
        (q.st == ILSU_ACCESS && mem_ack_i && q.is_load && q.size == ILSU_SZ_HALF && q.sign)
        |=> rf_we_o && rf_wdata_o[31:16] == {16{rf_wdata_o[15]}}
            && rf_wdata_o[15:0] == ($past(q.mem_addr[1]) ?
                $past(mem_rdata_i[15:0]) : $past(mem_rdata_i[31:16])))
        else $error("halfword algebraic load not sign extended");

    word_load_a: assert property (
        (q.st == ILSU_ACCESS && mem_ack_i && q.is_load && q.size == ILSU_SZ_WORD)
        |=> rf_we_o && rf_waddr_o == $past(q.rt) && rf_wdata_o == $past(mem_rdata_i))
        else $error("word load data altered");

    store_byte_a: assert property (
        (accept && !op_if.is_load && op_if.size == ILSU_SZ_BYTE)
        |=> mem_we_o && $countones(mem_be_o) == 1
            && mem_wdata_o[7:0] == $past(source_val_i[7:0]))
        else $error("byte store lanes wrong");

    store_half_a: assert property (
        (accept && !op_if.is_load && op_if.size == ILSU_SZ_HALF)
        |=> mem_we_o && $countones(mem_be_o) == 2
            && mem_wdata_o[15:0] == $past(source_val_i[15:0]))
        else $error("halfword store lanes wrong");

    store_word_a: assert property (
        (accept && !op_if.is_load && op_if.size == ILSU_SZ_WORD)
        |=> mem_be_o == 4'hF && mem_wdata_o == $past(source_val_i))
        else $error("word store data wrong");

    imm_addr_a: assert property (
        (accept && !op_if.indexed)
        |=> mem_addr_o == $past(((op_if.ra == REG_ZERO && !op_if.update) ? 32'h00000000
            : base_val_i) + {{16{op_if.simm[15]}}, op_if.simm}))
        else $error("immediate effective address wrong");

    index_addr_a: assert property (
        (accept && op_if.indexed && op_if.update)
        |=> mem_addr_o == $past(base_val_i + index_val_i))
        else $error("indexed update address wrong");

    zero_base_a: assert property (
        (accept && op_if.indexed && !op_if.update && op_if.ra == REG_ZERO)
        |=> mem_addr_o == $past(index_val_i))
        else $error("zero base field not treated as zero");

    store_update_a: assert property (
        (q.st == ILSU_ACCESS && mem_ack_i && !q.is_load && q.update)
        |=> rf_we_o && !mem_req_o && rf_waddr_o == $past(q.ra)
            && rf_wdata_o == $past(mem_addr_o))
        else $error("store update write-back wrong or early");

    load_update_a: assert property (
        (q.st == ILSU_ACCESS && mem_ack_i && q.is_load && q.update)
        |=> rf_waddr_o == $past(q.rt) ##1 rf_we_o && done_o
            && rf_waddr_o == $past(q.ra, 2) && rf_wdata_o == mem_addr_o)
        else $error("load update base write-back wrong");

    bad_form_a: assert property (
        (accept && op_if.update && (op_if.ra == REG_ZERO
            || (op_if.is_load && op_if.ra == op_if.rt)))
        |=> bad_form_o && busy_o)
        else $error("invalid update form not flagged");

    good_form_a: assert property (
        (accept && !op_if.update) |=> !bad_form_o)
        else $error("non-update form flagged invalid");

    // Reset leaves the unit idle with nothing pending
    reset_idle_a: assert property (
        $past(sys_rst_i) |-> !busy_o && !done_o && !mem_req_o && !rf_we_o && !bad_form_o)
        else $error("unit not idle after reset");

    // A waiting request keeps its address and direction
    req_hold_a: assert property (
        (mem_req_o && !mem_ack_i)
        |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request changed before acknowledge");

    // Completion is a single-cycle pulse
    done_pulse_a: assert property (
        done_o |=> !done_o)
        else $error("done held longer than one cycle");

    // Completion releases the unit and the memory request
    done_idle_a: assert property (
        done_o |-> !busy_o && !mem_req_o)
        else $error("unit still busy at completion");

    // Store update with a zero base still runs the store
    store_base_zero_a: assert property (
        (accept && !op_if.is_load && op_if.update && op_if.ra == REG_ZERO)
        |=> bad_form_o && mem_req_o && mem_we_o)
        else $error("store update with zero base not flagged");

    // Byte loads leave the high 24 bits clear
    zero_fill_a: assert property (
        (rf_we_o && q.wb_load && !q.sign && q.size == ILSU_SZ_BYTE)
        |-> rf_wdata_o[31:8] == 24'h000000)
        else $error("zero-extending load has high bits set");

    // Algebraic loads copy the operand top bit upward
    sign_fill_a: assert property (
        (rf_we_o && q.wb_load && q.sign)
        |-> rf_wdata_o[31:16] == {16{rf_wdata_o[15]}})
        else $error("algebraic load high bits not filled");

    // Immediate update forms use the raw base plus displacement
    imm_update_a: assert property (
        (accept && !op_if.indexed && op_if.update)
        |=> mem_addr_o == $past(base_val_i + {{16{op_if.simm[15]}}, op_if.simm}))
        else $error("immediate update address wrong");

    // No register write before the store reaches memory
    store_first_a: assert property (
        (accept && !op_if.is_load) |=> !rf_we_o && mem_req_o && mem_we_o)
        else $error("register written before store access");

    // Halfword store data sits in both halfword lanes
    half_copy_a: assert property (
        (mem_req_o && mem_we_o && q.size == ILSU_SZ_HALF)
        |-> mem_wdata_o[31:16] == mem_wdata_o[15:0])
        else $error("halfword store lanes differ");

    // Loads never drive write data to memory
    load_quiet_a: assert property (
        (accept && op_if.is_load) |=> !mem_we_o && mem_wdata_o == 32'h00000000)
        else $error("load drives store data");
endmodule

//--- sim/ilsu_mem_model.sv
// Behavioural data memory that answers the unit's single outstanding request
`timescale 1ns/1ns
module ilsu_mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [3:0] wait_i,
    input wire logic [31:0] word_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    initial begin
        ack_o = 1'b0;
        rdata_o = 32'h0000_0000;
        forever begin
            @(posedge clk_i);
            if (req_i === 1'b1) begin
                repeat (wait_i) @(posedge clk_i);
                #1;
                ack_o = 1'b1;
                rdata_o = word_i;
                @(posedge clk_i);
                #1;
                ack_o = 1'b0;
                // Data is gone after the answer; show its inverse, not a stale copy
                rdata_o = ~word_i;
            end
        end
    end
endmodule

//--- sim/integer_load_store_unit_bench.sv
// Self-checking bench of the integer load/store unit
`timescale 1ns/1ns
module integer_load_store_unit_bench import ilsu_pkg::*; ();
    typedef struct packed {
        logic [2:0] k;
        logic [4:0] ra;
        logic [31:0] b;
        logic [15:0] f;
        logic [31:0] exp;
    } ilsu_row_t;
    logic clk, rst, clk_en, iv, ack;
    logic [31:0] instr, base, idx, src, word, rdata, st_wd;
    logic [3:0] wait_n;
    logic busy_o, done_o, bad_form_o, mem_req_o, mem_we_o, rf_we_o;
    logic [31:0] mem_addr_o, mem_wdata_o, rf_wdata_o;
    logic [3:0] mem_be_o;
    logic [4:0] rf_waddr_o;
    logic [4:0] w_addr [2];
    logic [31:0] w_data [2];
    int nw, err_total, check_count;
    ilsu_row_t rows [9] = '{
        '{3'h1, 5'h04, 32'h0000_0003, 16'h0000, 32'h0000_005D},
        '{3'h5, 5'h04, 32'h0000_0000, 16'h0000, 32'hFFFF_8A7B},
        '{3'h5, 5'h04, 32'h0000_0010, 16'hFFF2, 32'h0000_6C5D},
        '{3'h4, 5'h04, 32'h0000_0001, 16'h0000, 32'h0000_8A7B},
        '{3'h0, 5'h04, 32'h0000_0006, 16'h0000, 32'h8A7B_6C5D},
        '{3'h3, 5'h04, 32'h0000_0002, 16'h0000, 32'hC4C4_C4C4},
        '{3'h6, 5'h04, 32'h0000_0000, 16'h0000, 32'hD3C4_D3C4},
        '{3'h2, 5'h04, 32'h0000_0000, 16'h0000, 32'hF1E2_D3C4},
        '{3'h1, 5'h00, 32'h0000_1234, 16'h0001, 32'h0000_007B}
    };

    ilsu_top i_ilsu_top (.sys_clk_i(clk), .sys_rst_i(rst), .clk_en_i(clk_en),
        .issue_valid_i(iv), .instr_i(instr), .base_val_i(base), .index_val_i(idx),
        .source_val_i(src), .mem_ack_i(ack), .mem_rdata_i(rdata), .busy_o(busy_o),
        .done_o(done_o), .bad_form_o(bad_form_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o),
        .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o));

    ilsu_mem_model i_ilsu_mem_model (.clk_i(clk), .req_i(mem_req_o), .wait_i(wait_n),
        .word_i(word), .ack_o(ack), .rdata_o(rdata));

    always #5 clk = ~clk;

    task automatic cmp(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Issue one operation, follow it to completion and compare every port
    task automatic exec_op(input logic [2:0] k, input logic ix, input logic u,
        input logic [4:0] rt, input logic [4:0] ra, input logic [15:0] f,
        input logic [31:0] b, input logic [3:0] wn);
        logic ld, sg;
        logic [1:0] sz;
        logic [31:0] ea, lv, wd;
        logic [3:0] be;
        int n;
        ld = k inside {3'h0, 3'h1, 3'h4, 3'h5};
        sg = k == 3'h5;
        sz = (k inside {3'h1, 3'h3}) ? 2'h0 : ((k inside {3'h4, 3'h5, 3'h6}) ? 2'h1 : 2'h2);
        ea = ((ra == 5'h00 && !u) ? 32'h0000_0000 : b) + (ix ? idx : {{16{f[15]}}, f});
        lv = word >> (sz == 2'h0 ? 8 * (3 - ea[1:0]) : ((sz == 2'h2 || ea[1]) ? 0 : 16));
        if (sz == 2'h0) lv = {24'h000000, lv[7:0]};
        if (sz == 2'h1) lv = sg ? {{16{lv[15]}}, lv[15:0]} : {16'h0000, lv[15:0]};
        be = sz == 2'h0 ? 4'h8 >> ea[1:0] : (sz == 2'h1 ? (ea[1] ? 4'h3 : 4'hC) : 4'hF);
        wd = ld ? 32'h0 : (sz == 2'h0 ? {4{src[7:0]}} : (sz == 2'h1 ? {2{src[15:0]}} : src));
        instr = ix ? {6'h1F, rt, ra, f[4:0], 1'b0, k, u, 5'h17, 1'b0} : {2'h2, k, u, rt, ra, f};
        base = b;
        wait_n = wn;
        nw = 0;
        iv = 1'b1;
        @(posedge clk);
        #1;
        iv = 1'b0;
        cmp({busy_o, mem_req_o, mem_we_o, mem_be_o, mem_addr_o, mem_wdata_o},
            {2'h3, !ld, be, ea, wd});
        cmp(bad_form_o, u && (ra == 5'h00 || (ld && ra == rt)));
        st_wd = mem_wdata_o;
        for (n = 0; n < 60 && done_o !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (rf_we_o === 1'b1) begin
                if (nw < 2) begin
                    w_addr[nw] = rf_waddr_o;
                    w_data[nw] = rf_wdata_o;
                end
                nw++;
            end
        end
        if (n == 60) begin
            err_total++;
            close_out();
        end
        cmp({busy_o, nw}, {1'b0, ld ? (u ? 2 : 1) : (u ? 1 : 0)});
        if (ld) cmp({w_addr[0], w_data[0]}, {rt, lv});
        if (u && nw inside {1, 2}) cmp({w_addr[nw - 1], w_data[nw - 1]}, {ra, ea});
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        iv = 1'b0;
        instr = 32'h0000_0000;
        base = 32'h0000_0000;
        idx = 32'h0000_0020;
        src = 32'hF1E2_D3C4;
        word = 32'h8A7B_6C5D;
        wait_n = 4'h0;
        err_total = 0;
        check_count = 0;
        nw = 0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        cmp({busy_o, done_o, bad_form_o, mem_req_o, mem_we_o, mem_addr_o, mem_be_o}, 0);
        cmp({mem_wdata_o, rf_we_o, rf_waddr_o, rf_wdata_o}, 0);
        foreach (rows[i]) begin
            exec_op(rows[i].k, 1'b0, 1'b0, 5'h03, rows[i].ra, rows[i].f, rows[i].b, 4'h1);
            cmp(rows[i].k inside {3'h2, 3'h3, 3'h6} ? st_wd : w_data[0],
                rows[i].exp);
        end
        // Every kind in both addressing modes, with and without write-back
        for (int i = 0; i < 28; i++) begin
            exec_op(3'(i >> 2), i[1], i[0], 5'h03, 5'h04, 16'hFFF1,
                32'h0000_1000 + i, 4'(i % 3));
        end
        // Invalid update forms still complete and raise the flag
        exec_op(KIND_LHA, 1'b0, 1'b1, 5'h03, 5'h00, 16'h0004, 32'h0000_0100, 4'h0);
        exec_op(KIND_LBZ, 1'b1, 1'b1, 5'h07, 5'h07, 16'h0000, 32'h0000_0200, 4'h2);
        exec_op(KIND_STH, 1'b0, 1'b1, 5'h03, 5'h00, 16'h0002, 32'h0000_0300, 4'h0);
        // Source and base are one register: old value stored, then address written
        src = 32'h0000_0400;
        exec_op(KIND_STW, 1'b0, 1'b1, 5'h05, 5'h05, 16'h0008, 32'h0000_0400, 4'h3);
        src = 32'hF1E2_D3C4;
        exec_op(KIND_LHA, 1'b1, 1'b1, 5'h03, 5'h04, 16'h0000, 32'h0000_0002, 4'h9);
        // Illegal opcode is ignored; a frozen clock enable holds the unit idle
        instr = 32'h0000_0000;
        iv = 1'b1;
        @(posedge clk);
        #1;
        cmp(busy_o, 1'b0);
        clk_en = 1'b0;
        instr = {2'h2, KIND_LWZ, 1'b0, 5'h01, 5'h02, 16'h0000};
        repeat (2) @(posedge clk);
        #1;
        cmp({busy_o, mem_req_o}, 2'h0);
        iv = 1'b0;
        clk_en = 1'b1;
        close_out();
    end
endmodule
